// ---- rtl/tls_pkg.sv ----
package tls_pkg;

  // ----------------------------------------------------------------
  // Timing figures
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ = 100_000_000;
  localparam int unsigned MASTER_CLK_HZ = 10_240_000;
  localparam int unsigned BIT_RATE_BPS = 5_120_000;
  // Fractional divider: step/modulus = master/core = 256/2500
  localparam logic [11:0] MCLK_STEP = 12'h100;
  localparam logic [11:0] MCLK_MOD = 12'h9C4;

  localparam int unsigned SLOT_TICKS = 1024;
  localparam int unsigned SLOTS_PER_TS = 512;
  localparam int unsigned FRAME_BITS = 234;
  localparam int unsigned GUARD_BITS = 22;
  localparam logic [8:0] SRV_TX_SLOT = 9'h000;
  localparam logic [8:0] CLI_TX_SLOT = 9'h100;

  // ----------------------------------------------------------------
  // Seconds to timestamp mapping
  // ----------------------------------------------------------------
  localparam logic [31:0] TICKS_PER_SEC_TS = 32'h0000_2710;
  localparam int unsigned SEC_WRAP_BITS = 18;
  localparam int unsigned TS_SHIFT = 10;

  // ----------------------------------------------------------------
  // Protection switching hold-off
  // ----------------------------------------------------------------
  localparam int unsigned FAILOVER_MS = 500;
  localparam int unsigned FAILOVER_CYCLES = FAILOVER_MS * (CORE_CLK_HZ / 1000);

  localparam logic [3:0] NTP_MIN_VERSION = 4'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TOD_USER,
    TOD_DEFAULT,
    TOD_NTP,
    TOD_GPS
  } tls_tod_src_t;

  typedef struct packed {
    logic line_positive;
    logic line_negative;
    logic oe;
  } tls_line_t;

endpackage

// ---- rtl/tls_scheduler.sv ----
// Functional notes
// - Manchester line at 5.12 Mbps from master clock
// - One pair shared, only one side drives
// - Timeslot is 1024 master periods, 100 us
// - Bit period is two counts, even first
// - Bit slot is (counter mod 1024)/2
// - Client slot count restarts on each received frame start, wraps at 512
// - Server frame reaches client in slot 0
// - Client preamble starts in slot 256
// - First half server, second half client
// - Frames 234 bits, then 22-bit silent guard
// - Client turns around within server guard
// - Server receives then turns around in guard
// - Client output advanced by cable advance value
// - Received frame released only after CRC check
// - Failover waits at least 500 ms
// - 32-bit timestamp counts master clock periods
// - 32-bit seconds count, zero at epoch
// - Counter loaded from seconds mapping on second
// - Any time source converted to seconds count
// - Four selectable time-of-day sources
// - NTP source needs version 3 or later
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Transmit data FIFO
// ------------------------------------------------------------------
module tls_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 16
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ------------------------------------------------------------------
// Timeslot scheduler
// ------------------------------------------------------------------
module tls_scheduler import tls_pkg::*; #(
  parameter int unsigned FAILOVER_CYC = FAILOVER_CYCLES,
  parameter int unsigned FIFO_DEPTH = 16
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic server_mode_i,
  input wire logic pps_i,
  input wire logic los_i,
  input wire logic tod_load_i,
  input wire tls_tod_src_t tod_src_i,
  input wire logic [31:0] user_sec_i,
  input wire logic [31:0] default_sec_i,
  input wire logic [31:0] ntp_sec_i,
  input wire logic [3:0] ntp_version_i,
  input wire logic [31:0] gps_sec_i,
  input wire logic [8:0] adv_slots_i,
  input wire logic rx_sof_i,
  input wire logic rx_bit_valid_i,
  input wire logic rx_bit_i,
  input wire logic rx_crc_done_i,
  input wire logic rx_crc_ok_i,
  input wire logic tx_valid_i,
  input wire logic tx_bit_i,
  output logic tx_ready_o,
  output tls_line_t line_o,
  output logic [31:0] timestamp_o,
  output logic [31:0] gps_sec_o,
  output logic [8:0] bit_slot_o,
  output logic [FRAME_BITS-1:0] rx_frame_o,
  output logic rx_frame_valid_o,
  output logic protect_sel_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] sec_to_ts(input logic [31:0] sec);
    logic [31:0] prod;
    prod = TICKS_PER_SEC_TS * {14'h0000, sec[SEC_WRAP_BITS-1:0]};
    return {prod[31-TS_SHIFT:0], 10'h000};
  endfunction

  function automatic logic in_frame(input logic [8:0] slot, input logic [8:0] start);
    logic [8:0] rel;
    rel = slot - start;
    return (rel < 9'(FRAME_BITS));
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic pps_m_q;
  logic pps_s_q;
  logic pps_d_q;
  logic los_m_q;
  logic los_s_q;
  logic pps_rise;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pps_m_q <= 1'b0;
      pps_s_q <= 1'b0;
      pps_d_q <= 1'b0;
      los_m_q <= 1'b0;
      los_s_q <= 1'b0;
    end else begin
      pps_m_q <= pps_i;
      pps_s_q <= pps_m_q;
      pps_d_q <= pps_s_q;
      los_m_q <= los_i;
      los_s_q <= los_m_q;
    end
  end

  assign pps_rise = pps_s_q && !pps_d_q;

  // ----------------------------------------------------------------
  // Master clock enable (10.24 MHz average from 100 MHz)
  // ----------------------------------------------------------------
  logic [11:0] acc_q;
  logic [11:0] acc_sum;
  logic mtick;

  assign acc_sum = acc_q + MCLK_STEP;
  assign mtick = (acc_sum >= MCLK_MOD);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      acc_q <= '0;
    end else begin
      acc_q <= mtick ? acc_sum - MCLK_MOD : acc_sum;
    end
  end

  // ----------------------------------------------------------------
  // Time-of-day source and seconds count
  // ----------------------------------------------------------------
  logic [31:0] src_sec;
  logic src_ok;
  logic load_arm_q;
  logic load_now;
  logic [31:0] sec_q;

  always_comb begin
    src_ok = 1'b1;
    case (tod_src_i)
      TOD_USER: src_sec = user_sec_i;
      TOD_DEFAULT: src_sec = default_sec_i;
      TOD_NTP: begin
        src_sec = ntp_sec_i;
        src_ok = (ntp_version_i >= NTP_MIN_VERSION);
      end
      TOD_GPS: src_sec = gps_sec_i;
      default: src_sec = gps_sec_i;
    endcase
  end

  assign load_now = load_arm_q && pps_rise;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      load_arm_q <= 1'b0;
    end else if (tod_load_i && src_ok) begin
      load_arm_q <= 1'b1;
    end else if (load_now) begin
      load_arm_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sec_q <= '0;
    end else if (load_now) begin
      sec_q <= src_sec;
    end else if (pps_rise) begin
      sec_q <= sec_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Timestamp counter
  // ----------------------------------------------------------------
  logic [31:0] ts_q;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ts_q <= '0;
    end else if (load_now) begin
      ts_q <= sec_to_ts(src_sec);
    end else if (mtick) begin
      ts_q <= ts_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Client slot tracking
  // ----------------------------------------------------------------
  logic [9:0] cli_cnt_q;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cli_cnt_q <= '0;
    end else if (rx_sof_i && !server_mode_i) begin
      cli_cnt_q <= '0;
    end else if (mtick) begin
      cli_cnt_q <= cli_cnt_q + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Slot position and frame ownership
  // ----------------------------------------------------------------
  logic [9:0] pos_nxt;
  logic [8:0] slot_nxt;
  logic [8:0] tx_slot;
  logic half_nxt;
  logic own_nxt;

  assign pos_nxt = (server_mode_i ? ts_q[9:0] : cli_cnt_q) + 10'h001;
  assign slot_nxt = pos_nxt[9:1];
  assign half_nxt = pos_nxt[0];
  // Client output is pulled earlier by the cable advance
  assign tx_slot = server_mode_i ? slot_nxt : slot_nxt + adv_slots_i;
  // Server owns the first half, client the second; guards stay idle
  assign own_nxt = server_mode_i ? in_frame(tx_slot, SRV_TX_SLOT)
                                 : in_frame(tx_slot, CLI_TX_SLOT);

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  logic fifo_valid;
  logic fifo_data;
  logic fifo_pop;
  logic cur_bit_q;
  logic new_bit;
  tls_line_t line_q;
  logic in_ready;

  assign fifo_pop = mtick && own_nxt && !half_nxt;
  assign new_bit = fifo_valid ? fifo_data : 1'b0;

  tls_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(tx_valid_i),
    .in_data_i(tx_bit_i),
    .in_ready_o(in_ready),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_pop)
  );

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_ready_o <= 1'b0;
    end else begin
      tx_ready_o <= in_ready;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cur_bit_q <= 1'b0;
    end else if (fifo_pop) begin
      cur_bit_q <= new_bit;
    end
  end

  // Manchester: first half carries the bit, second half its inverse
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      line_q <= '0;
    end else if (mtick) begin
      if (own_nxt) begin
        line_q.oe <= 1'b1;
        line_q.line_positive <= half_nxt ? ~cur_bit_q : new_bit;
        line_q.line_negative <= half_nxt ? cur_bit_q : ~new_bit;
      end else begin
        line_q <= '0;
      end
    end
  end

  assign line_o = line_q;

  // ----------------------------------------------------------------
  // Receive frame buffer
  // ----------------------------------------------------------------
  logic [FRAME_BITS-1:0] rx_shift_q;
  logic [FRAME_BITS-1:0] rx_frame_q;
  logic rx_frame_valid_q;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_shift_q <= '0;
    end else if (rx_bit_valid_i && !line_q.oe) begin
      rx_shift_q <= {rx_shift_q[FRAME_BITS-2:0], rx_bit_i};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_frame_q <= '0;
      rx_frame_valid_q <= 1'b0;
    end else begin
      rx_frame_valid_q <= rx_crc_done_i && rx_crc_ok_i;
      if (rx_crc_done_i && rx_crc_ok_i) begin
        rx_frame_q <= rx_shift_q;
      end
    end
  end

  assign rx_frame_o = rx_frame_q;
  assign rx_frame_valid_o = rx_frame_valid_q;

  // ----------------------------------------------------------------
  // Protection failover hold-off
  // ----------------------------------------------------------------
  logic [31:0] los_cnt_q;
  logic prot_q;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      los_cnt_q <= '0;
      prot_q <= 1'b0;
    end else if (!los_s_q) begin
      los_cnt_q <= '0;
      prot_q <= 1'b0;
    end else if (los_cnt_q < 32'(FAILOVER_CYC)) begin
      los_cnt_q <= los_cnt_q + 32'h0000_0001;
    end else begin
      prot_q <= 1'b1;
    end
  end

  assign protect_sel_o = prot_q;

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  assign timestamp_o = ts_q;
  assign gps_sec_o = sec_q;

  logic [8:0] slot_q;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      slot_q <= '0;
    end else begin
      slot_q <= server_mode_i ? ts_q[9:1] : cli_cnt_q[9:1];
    end
  end

  assign bit_slot_o = slot_q;

endmodule

// ---- sim/tls_scheduler_properties.sv ----
`timescale 1ns/1ps

module tls_sched_props import tls_pkg::*; #(
  parameter int unsigned FAILOVER_CYC = 20
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic server_mode_i,
  input wire logic pps_i,
  input wire logic los_i,
  input wire logic [8:0] adv_slots_i,
  input wire logic rx_crc_done_i,
  input wire logic rx_crc_ok_i,
  input wire tls_line_t line_o,
  input wire logic [31:0] timestamp_o,
  input wire logic [8:0] bit_slot_o,
  input wire logic rx_frame_valid_o,
  input wire logic protect_sel_o
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  // Keeps checks away from timestamp loads at the one-second edge
  logic [15:0] pps_hist_q;
  logic [31:0] los_cnt_q;
  logic [8:0] cli_pos;
  assign cli_pos = bit_slot_o + adv_slots_i;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pps_hist_q <= 16'h0000;
    end else begin
      pps_hist_q <= {pps_hist_q[14:0], pps_i};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !los_i) begin
      los_cnt_q <= 32'h0;
    end else if (los_cnt_q != 32'hFFFF_FFFF) begin
      los_cnt_q <= los_cnt_q + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_valid_pulse;
    rx_frame_valid_o ##1 !rx_frame_valid_o;
  endsequence
  sequence s_ts_moves;
    ##[1:10] (timestamp_o != $past(timestamp_o));
  endsequence

  property p_ts_step;
    pps_hist_q == 16'h0 |-> timestamp_o - $past(timestamp_o) <= 32'h1;
  endproperty
  a_ts_step: assert property (p_ts_step) else $error("timestamp step");
  property p_ts_live;
    pps_hist_q == 16'h0 |-> s_ts_moves;
  endproperty
  a_ts_live: assert property (p_ts_live) else $error("timestamp stalled");
  property p_slot;
    server_mode_i |-> bit_slot_o == timestamp_o[9:1] || bit_slot_o == $past(timestamp_o[9:1]);
  endproperty
  a_slot: assert property (p_slot) else $error("bit slot mismatch");
  property p_manch;
    line_o.oe |-> line_o.line_negative != line_o.line_positive;
  endproperty
  a_manch: assert property (p_manch) else $error("line pair not complementary");
  property p_line_tick;
    $changed(line_o) |-> timestamp_o != $past(timestamp_o);
  endproperty
  a_line_tick: assert property (p_line_tick) else $error("line moved off tick");
  // Registered slot lags the line by one tick position
  property p_srv_oe;
    server_mode_i && line_o.oe && pps_hist_q == 16'h0 |-> bit_slot_o < 9'h0EA ||
      bit_slot_o == 9'h1FF;
  endproperty
  a_srv_oe: assert property (p_srv_oe) else $error("server drives in guard");
  property p_cli_oe;
    !server_mode_i && line_o.oe |-> cli_pos >= 9'h0FF && cli_pos <= 9'h1E9;
  endproperty
  a_cli_oe: assert property (p_cli_oe) else $error("client drives off window");
  property p_rx_pulse;
    rx_crc_done_i && rx_crc_ok_i |=> s_valid_pulse;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("frame valid pulse");
  property p_rx_cause;
    rx_frame_valid_o |-> $past(rx_crc_done_i && rx_crc_ok_i);
  endproperty
  a_rx_cause: assert property (p_rx_cause) else $error("frame valid unasked");
  property p_fo_hold;
    $rose(protect_sel_o) |-> los_cnt_q >= FAILOVER_CYC;
  endproperty
  a_fo_hold: assert property (p_fo_hold) else $error("failover too early");
  property p_fo_set;
    los_cnt_q == FAILOVER_CYC + 8 |-> protect_sel_o;
  endproperty
  a_fo_set: assert property (p_fo_set) else $error("failover missing");
endmodule

bind tls_scheduler tls_sched_props #(.FAILOVER_CYC(FAILOVER_CYC)) i_props (
  .core_clk_i, .sys_rst_i, .server_mode_i, .pps_i, .los_i, .adv_slots_i, .rx_crc_done_i,
  .rx_crc_ok_i, .line_o, .timestamp_o, .bit_slot_o, .rx_frame_valid_o, .protect_sel_o
);

// ---- sim/tls_peer_model.sv ----
`timescale 1ns/1ps

module tls_peer_model (
  input wire logic core_clk_i,
  input wire logic line_oe_i,
  output logic rx_sof_o,
  output logic rx_bit_valid_o,
  output logic rx_bit_o,
  output logic rx_crc_done_o,
  output logic rx_crc_ok_o
);
  initial begin
    rx_sof_o = 0;
    rx_bit_valid_o = 0;
    rx_bit_o = 0;
    rx_crc_done_o = 0;
    rx_crc_ok_o = 0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // Hold off the start and bit strobes while the local side owns the pair
  task automatic idle_line;
    while (line_oe_i) begin
      step(1);
    end
  endtask

  task automatic send_frame(input logic [233:0] f, input logic ok, input int gap);
    idle_line();
    rx_sof_o = 1;
    step(1);
    rx_sof_o = 0;
    for (int i = 233; i >= 0; i--) begin
      idle_line();
      rx_bit_valid_o = 1;
      rx_bit_o = f[i];
      step(1);
      rx_bit_valid_o = 0;
      rx_bit_o = ~f[i];
      step(gap);
    end
    rx_crc_done_o = 1;
    rx_crc_ok_o = ok;
    step(1);
    rx_crc_done_o = 0;
    rx_crc_ok_o = 0;
  endtask
endmodule

// ---- sim/tls_scheduler_test.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end

module tls_scheduler_test import tls_pkg::*;;
  localparam int unsigned FO = 20;
  logic core_clk_i, sys_rst_i, server_mode_i, pps_i, los_i, tod_load_i;
  logic rx_sof_i, rx_bit_valid_i, rx_bit_i, rx_crc_done_i, rx_crc_ok_i;
  logic tx_valid_i, tx_bit_i, tx_ready_o, rx_frame_valid_o, protect_sel_o;
  tls_tod_src_t tod_src_i;
  logic [31:0] user_sec_i, default_sec_i, ntp_sec_i, gps_sec_i, timestamp_o, gps_sec_o;
  logic [31:0] exp_sec;
  logic [3:0] ntp_version_i;
  logic [8:0] adv_slots_i, bit_slot_o;
  tls_line_t line_o;
  logic [FRAME_BITS-1:0] rx_frame_o;
  int n_mismatch, tests_run;

  tls_scheduler #(.FAILOVER_CYC(FO)) i_dut (.core_clk_i, .sys_rst_i, .server_mode_i,
    .pps_i, .los_i, .tod_load_i, .tod_src_i, .user_sec_i, .default_sec_i, .ntp_sec_i,
    .ntp_version_i, .gps_sec_i, .adv_slots_i, .rx_sof_i, .rx_bit_valid_i, .rx_bit_i,
    .rx_crc_done_i, .rx_crc_ok_i, .tx_valid_i, .tx_bit_i, .tx_ready_o, .line_o,
    .timestamp_o, .gps_sec_o, .bit_slot_o, .rx_frame_o, .rx_frame_valid_o, .protect_sel_o);
  tls_peer_model i_peer (.core_clk_i, .line_oe_i(line_o.oe), .rx_sof_o(rx_sof_i),
    .rx_bit_valid_o(rx_bit_valid_i), .rx_bit_o(rx_bit_i), .rx_crc_done_o(rx_crc_done_i),
    .rx_crc_ok_o(rx_crc_ok_i));

  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  initial begin
    core_clk_i = 0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic do_reset(input logic srv);
    sys_rst_i = 1;
    server_mode_i = srv;
    tick(10);
    `CHK("ts_rst", 32'h0, timestamp_o)
    `CHK("oe_rst", 1'b0, line_o.oe)
    sys_rst_i = 0;
  endtask

  task automatic arm_and_pps;
    tod_load_i = 1;
    tick(1);
    tod_load_i = 0;
    pps_i = 1;
    tick(4);
    pps_i = 0;
    tick(4);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_count;
    logic [31:0] t0;
    t0 = timestamp_o;
    tick(2500);
    `CHK("ticks", 32'h0000_0100, timestamp_o - t0)
  endtask

  task automatic t_load;
    logic [31:0] ts_exp;
    for (int s = 0; s < 4; s++) begin
      exp_sec = 32'h0004_1230 + 32'(s);
      {user_sec_i, default_sec_i, ntp_sec_i, gps_sec_i} = {4{32'h0}};
      case (s)
        0: user_sec_i = exp_sec;
        1: default_sec_i = exp_sec;
        2: ntp_sec_i = exp_sec;
        default: gps_sec_i = exp_sec;
      endcase
      tod_src_i = tls_tod_src_t'(s);
      arm_and_pps();
      ts_exp = ((exp_sec & 32'h0003_FFFF) * 32'h0000_2710) << 10;
      `CHK("tod_sec", exp_sec, gps_sec_o)
      `CHK("tod_ts", 1'b1, (timestamp_o - ts_exp) <= 32'h1)
    end
    tod_src_i = TOD_NTP;
    ntp_version_i = 4'h2;
    arm_and_pps();
    `CHK("ntp_refused", exp_sec + 32'h1, gps_sec_o)
  endtask

  task automatic t_tx;
    logic [39:0] got, expv;
    logic [31:0] prev;
    int n, k;
    n = 0;
    k = 0;
    for (int i = 0; i < 20000 && bit_slot_o != 9'h0F0; i++) tick(1);
    tx_bit_i = 1;
    for (int i = 0; i < 40 && tx_ready_o; i++) begin
      tx_valid_i = 1;
      tick(1);
      tx_valid_i = 0;
      tick(1);
      n++;
    end
    `CHK("fifo_fill", 16, n)
    for (int i = 0; i < 12000 && !line_o.oe; i++) tick(1);
    prev = timestamp_o - 32'h1;
    for (int i = 0; i < 1000 && k < 40; i++) begin
      if (timestamp_o != prev) begin
        got[39-k] = line_o.line_positive;
        prev = timestamp_o;
        k++;
      end
      tick(1);
    end
    for (int j = 0; j < 40; j++) expv[39-j] = (j < 32) ? (j % 2 == 0) : (j % 2 == 1);
    `CHK("manchester", expv, got)
    // Count the remaining driven half bits up to the guard
    for (int i = 0; i < 6000 && line_o.oe; i++) begin
      if (timestamp_o != prev) begin
        prev = timestamp_o;
        k++;
      end
      tick(1);
    end
    `CHK("srv_frame_len", 2 * FRAME_BITS, k)
  endtask

  task automatic t_los;
    los_i = 1;
    tick(10);
    los_i = 0;
    tick(5);
    `CHK("prot_early", 1'b0, protect_sel_o)
    los_i = 1;
    tick(FO + 10);
    `CHK("prot_set", 1'b1, protect_sel_o)
    los_i = 0;
  endtask

  task automatic t_rx;
    logic [FRAME_BITS-1:0] frame;
    logic [8:0] pos;
    logic seen;
    frame = {18{13'h1A5B}};
    seen = 0;
    i_peer.send_frame(frame, 1'b1, 0);
    `CHK("rx_valid", 1'b1, rx_frame_valid_o)
    `CHK("rx_data", frame, rx_frame_o)
    i_peer.send_frame(~frame, 1'b0, 2);
    for (int i = 0; i < 4; i++) begin
      seen = seen | rx_frame_valid_o;
      tick(1);
    end
    `CHK("rx_bad_valid", 1'b0, seen)
    `CHK("rx_bad_keep", frame, rx_frame_o)
    for (int i = 0; i < 12000 && !line_o.oe; i++) tick(1);
    pos = bit_slot_o + adv_slots_i;
    `CHK("cli_start", 1'b1, pos inside {9'h0FF, 9'h100})
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {pps_i, los_i, tod_load_i, tx_valid_i, tx_bit_i} = 5'h00;
    {user_sec_i, default_sec_i, ntp_sec_i, gps_sec_i} = {4{32'h0}};
    tod_src_i = TOD_USER;
    ntp_version_i = 4'h3;
    adv_slots_i = 9'h000;
    n_mismatch = 0;
    tests_run = 0;
    do_reset(1'b1);
    t_count();
    t_load();
    t_tx();
    t_los();
    adv_slots_i = 9'h005;
    do_reset(1'b0);
    t_rx();
    print_verdict();
  end

  // Roughly three and a half times the cycles the scenarios need
  initial begin
    #800_000;
    n_mismatch++;
    print_verdict();
  end
endmodule
